//--- core/phy_mgmt_cfg.svh
// offsets, field positions, reset values and timing counts of the phy
// management block; included by the design files that need them
`ifndef PHY_MGMT_CFG_SVH
`define PHY_MGMT_CFG_SVH

`define OFS_SYSTEM_CONFIG_ONE 8'h00
`define OFS_PHY_CONTROL_ONE 8'h01
`define OFS_PHY_MODE_CONTROL 8'h02
`define OFS_PHY_LINK_STATUS 8'h03
`define OFS_PHY_LOCK_KEY 8'h04
`define OFS_MGMT_REG_ADDRESS 8'h05
`define OFS_MGMT_WRITE_LOW 8'h06
`define OFS_MGMT_WRITE_HIGH 8'h07
`define OFS_MGMT_READ_LOW 8'h08
`define OFS_MGMT_READ_HIGH 8'h09
`define OFS_MGMT_ACCESS_COMMAND 8'h0a
`define OFS_MGMT_CLOCK_DIVIDER 8'h0b
`define OFS_CLOCK_STATUS 8'h0c

`define BIT_SLOW_CLOCK_SELECT 0
`define BIT_PHY_RUN 7
`define BIT_PHY_POWER_DOWN 5
`define BIT_FORCED_MODE 2
`define BIT_CLOCK_FAST 0
`define BIT_CLOCK_STABLE 1

`define RST_PHY_CONTROL_ONE 8'h80
`define RST_PHY_MODE_CONTROL 3'h0
`define RST_MGMT_CLOCK_DIVIDER 8'h01

`define LOCK_KEY 8'h53
`define CMD_WRITE 8'h01
`define CMD_READ 8'h02
`define CMD_IDLE 8'h00

`define CLK_MHZ 25
`define T_SETTLE_NS 300
`define T_PHY_RESET_NS 350
`define SETTLE_CYC ((`T_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define PHY_RESET_CYC ((`T_PHY_RESET_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- core/phy_mgmt_pkg.sv
// types shared by the phy management block
// assumes nothing beyond a SystemVerilog compiler
package phy_mgmt_pkg;
    typedef enum logic {MDIO_OP_WRITE, MDIO_OP_READ} mdio_op_t;
    typedef enum {ENG_IDLE, ENG_RUN} eng_state_t;
endpackage

//--- core/mdio_req_if.sv
// request and answer between the register block and the mdio engine
// assumes both ends run on the same system clock
interface mdio_req_if;
    logic start;
    phy_mgmt_pkg::mdio_op_t op;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
    logic [7:0] divider;
    logic busy;
    logic done;
    logic [15:0] rdata;
    modport ctrl (output start, op, phy_addr, reg_addr, wdata, divider,
                  input busy, done, rdata);
    modport eng (input start, op, phy_addr, reg_addr, wdata, divider,
                 output busy, done, rdata);
endinterface

//--- core/mdio_engine.sv
// clause 22 management frame engine: preamble, start, op, addresses,
// turnaround, 16 data bits; mdc derived from the system clock
// assumes one request at a time, started only while busy is low
module mdio_engine #(
    parameter int PRE_BITS = 32
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    mdio_req_if.eng req,
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_n_o
);
    localparam int FRAME = PRE_BITS + 32;
    localparam int RD_REL = PRE_BITS + 14;
    localparam int RD_DATA = FRAME - 16;

    if (PRE_BITS < 1 || PRE_BITS > 32)
    begin : g_check
        $error("preamble length out of range");
    end

    phy_mgmt_pkg::eng_state_t state;
    logic [7:0] tick_cnt;
    logic [6:0] bit_cnt;
    logic [FRAME-1:0] shreg;
    logic is_read;
    logic tick;

    // half period of mdc is divider+1 system clocks
    assign tick = (tick_cnt >= req.divider);
    assign req.busy = (state == phy_mgmt_pkg::ENG_RUN);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tick_cnt <= 8'h00;
        else if (state == phy_mgmt_pkg::ENG_IDLE || tick)
            tick_cnt <= 8'h00;
        else
            tick_cnt <= tick_cnt + 8'h01;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= phy_mgmt_pkg::ENG_IDLE;
            bit_cnt <= 7'h00;
            shreg <= '0;
            is_read <= 1'b0;
            mdc_o <= 1'b0;
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1;
            req.done <= 1'b0;
        end
        else
        begin
            req.done <= 1'b0;
            unique case (state)
                phy_mgmt_pkg::ENG_IDLE:
                begin
                    if (req.start)
                    begin
                        is_read <= (req.op == phy_mgmt_pkg::MDIO_OP_READ);
                        shreg <= {{PRE_BITS{1'b1}}, 2'b01,
                                  (req.op == phy_mgmt_pkg::MDIO_OP_READ)
                                  ? 2'b10 : 2'b01,
                                  req.phy_addr, req.reg_addr, 2'b10,
                                  req.wdata};
                        bit_cnt <= 7'h00;
                        mdio_o <= 1'b1;
                        mdio_oe_n_o <= 1'b0;
                        state <= phy_mgmt_pkg::ENG_RUN;
                    end
                end
                phy_mgmt_pkg::ENG_RUN:
                begin
                    if (tick && !mdc_o)
                        mdc_o <= 1'b1;
                    else if (tick)
                    begin
                        // bits change on the falling edge, so the phy
                        // sees half a period of setup before rising
                        mdc_o <= 1'b0;
                        if (int'(bit_cnt) == FRAME - 1)
                        begin
                            state <= phy_mgmt_pkg::ENG_IDLE;
                            mdio_oe_n_o <= 1'b1;
                            mdio_o <= 1'b1;
                            req.done <= 1'b1;
                        end
                        else
                        begin
                            bit_cnt <= bit_cnt + 7'h01;
                            shreg <= {shreg[FRAME-2:0], 1'b0};
                            mdio_o <= shreg[FRAME-2];
                            mdio_oe_n_o <= is_read &&
                                (int'(bit_cnt) + 1 >= RD_REL);
                        end
                    end
                end
            endcase
        end
    end

    // read data sampled on the rising mdc edge
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            req.rdata <= 16'h0000;
        else if (state == phy_mgmt_pkg::ENG_RUN && tick && !mdc_o
                 && is_read && int'(bit_cnt) >= RD_DATA)
            req.rdata <= {req.rdata[14:0], mdio_i};
    end
endmodule

//--- core/phy_mgmt.sv
// phy management and clock select: lock-guarded phy control, clock
// select, phy reset sequencing and a register-driven mdio controller
// assumes a single-master register port and a 25 MHz system clock
//
// Functional notes
// - core clock fast only when select 0, phy running, not powered down
// - clock needs a settle interval after a switch; status shows it
// - speed and duplex mode take effect only after a phy hardware reset
// - link status shows operating mode in 5:3 while the link is up (000 otherwise) and link state in 2:0
// - mode control writes accepted only while the lock is open
// - key 0x53 unlocks both control registers; any other value locks
// - mode codes: 000 auto, 100/101 100M full/half, 110/111 10M
// - without partner auto-negotiation the phy uses parallel detection
// - auto crossover only when the forced mode bit is zero
// - power-down set enters power-down and drops to 25 MHz
// - power-down cleared restores normal mode and the clock select
// - write data is high byte from write high, low from write low
// - command 0x01 writes the phy register, then clears to zero
// - command 0x02 reads the phy register, then clears to zero
// - read data: high byte in read high, low byte in read low
`include "phy_mgmt_cfg.svh"
module phy_mgmt #(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter int PRE_BITS = 32
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic link_up_i,
    input wire logic [2:0] link_mode_i,
    input wire logic [2:0] link_state_i,
    output logic core_clock_fast_o,
    output logic clock_stable_o,
    output logic phy_power_down_o,
    output logic phy_reset_n_o,
    output logic [2:0] phy_mode_o,
    output logic auto_mdix_o,
    output logic parallel_detect_o,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    input wire logic mdio_i
);
    localparam int SETTLE_CYC = `SETTLE_CYC;
    localparam int PHY_RESET_CYC = `PHY_RESET_CYC;
    localparam logic [7:0] RST_CTRL = `RST_PHY_CONTROL_ONE;

    if (SETTLE_CYC < 1 || SETTLE_CYC > 255 ||
        PHY_RESET_CYC < 1 || PHY_RESET_CYC > 255)
    begin : g_check
        $error("timing count does not fit its counter");
    end

    function automatic logic hit(input logic [7:0] ofs);
        hit = (addr_i == ofs);
    endfunction

    mdio_req_if mreq ();

    logic slow_clock_select;
    logic phy_run;
    logic phy_power_down;
    logic [2:0] phy_mode_control;
    logic unlocked;
    logic [4:0] mgmt_reg_address;
    logic [7:0] mgmt_write_low;
    logic [7:0] mgmt_write_high;
    logic [7:0] mgmt_read_low;
    logic [7:0] mgmt_read_high;
    logic [7:0] mgmt_access_command;
    logic [7:0] mgmt_clock_divider;
    logic [7:0] settle_cnt;
    logic [7:0] reset_cnt;
    logic phy_in_reset;
    logic next_fast;
    logic [2:0] phy_mode_eff;
    logic ctrl_wr;
    logic cmd_wr;
    logic [7:0] next_rdata;

    // both control registers share the one lock
    assign ctrl_wr = wr_i && unlocked;
    assign cmd_wr = wr_i && hit(`OFS_MGMT_ACCESS_COMMAND);

    // lock key: only the exact key opens, anything else closes
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            unlocked <= 1'b0;
        else if (wr_i && hit(`OFS_PHY_LOCK_KEY))
            unlocked <= (wdata_i == `LOCK_KEY);
    end

    // clock select is not behind the lock
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            slow_clock_select <= 1'b0;
        else if (wr_i && hit(`OFS_SYSTEM_CONFIG_ONE))
            slow_clock_select <= wdata_i[`BIT_SLOW_CLOCK_SELECT];
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            phy_run <= RST_CTRL[`BIT_PHY_RUN];
            phy_power_down <= RST_CTRL[`BIT_PHY_POWER_DOWN];
        end
        else if (ctrl_wr && hit(`OFS_PHY_CONTROL_ONE))
        begin
            phy_run <= wdata_i[`BIT_PHY_RUN];
            phy_power_down <= wdata_i[`BIT_PHY_POWER_DOWN];
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            phy_mode_control <= `RST_PHY_MODE_CONTROL;
        else if (ctrl_wr && hit(`OFS_PHY_MODE_CONTROL))
            phy_mode_control <= wdata_i[2:0];
    end

    // run bit written as one gives a timed reset pulse
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reset_cnt <= 8'h00;
        else if (ctrl_wr && hit(`OFS_PHY_CONTROL_ONE)
                 && wdata_i[`BIT_PHY_RUN])
            reset_cnt <= 8'(PHY_RESET_CYC);
        else if (reset_cnt != 8'h00)
            reset_cnt <= reset_cnt - 8'h01;
    end

    assign phy_in_reset = !phy_run || (reset_cnt != 8'h00);

    // mode latches only while the phy sits in reset
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            phy_mode_eff <= `RST_PHY_MODE_CONTROL;
        else if (phy_in_reset)
            phy_mode_eff <= phy_mode_control;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            phy_reset_n_o <= 1'b1;
            phy_power_down_o <= 1'b0;
            phy_mode_o <= `RST_PHY_MODE_CONTROL;
            auto_mdix_o <= 1'b1;
            parallel_detect_o <= 1'b1;
        end
        else
        begin
            phy_reset_n_o <= !phy_in_reset;
            phy_power_down_o <= phy_power_down;
            phy_mode_o <= phy_mode_eff;
            auto_mdix_o <= !phy_mode_eff[`BIT_FORCED_MODE];
            // parallel detection rides along with auto-negotiation
            parallel_detect_o <= !phy_mode_eff[`BIT_FORCED_MODE];
        end
    end

    // fast clock needs all three conditions; power-down forces slow
    assign next_fast = !slow_clock_select && phy_run
                       && !phy_power_down;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            core_clock_fast_o <= 1'b1;
        else
            core_clock_fast_o <= next_fast;
    end

    // any switch restarts the settle count; stable only at zero
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            settle_cnt <= 8'h00;
        else if (next_fast != core_clock_fast_o)
            settle_cnt <= 8'(SETTLE_CYC);
        else if (settle_cnt != 8'h00)
            settle_cnt <= settle_cnt - 8'h01;
    end

    assign clock_stable_o = (settle_cnt == 8'h00)
                            && (next_fast == core_clock_fast_o);

    // the engine latches address and write data at frame start; it reads the divider live
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mgmt_reg_address <= 5'h00;
        else if (wr_i && hit(`OFS_MGMT_REG_ADDRESS))
            mgmt_reg_address <= wdata_i[4:0];
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mgmt_write_low <= 8'h00;
            mgmt_write_high <= 8'h00;
        end
        else if (wr_i && hit(`OFS_MGMT_WRITE_LOW))
            mgmt_write_low <= wdata_i;
        else if (wr_i && hit(`OFS_MGMT_WRITE_HIGH))
            mgmt_write_high <= wdata_i;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mgmt_clock_divider <= `RST_MGMT_CLOCK_DIVIDER;
        else if (wr_i && hit(`OFS_MGMT_CLOCK_DIVIDER))
            mgmt_clock_divider <= wdata_i;
    end

    // only 0x01/0x02 taken, only while idle; done clears it
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mgmt_access_command <= `CMD_IDLE;
        else if (cmd_wr && mgmt_access_command == `CMD_IDLE
                 && (wdata_i == `CMD_WRITE || wdata_i == `CMD_READ))
            mgmt_access_command <= wdata_i;
        else if (mreq.done)
            mgmt_access_command <= `CMD_IDLE;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mreq.start <= 1'b0;
        else
            mreq.start <= cmd_wr && !mreq.busy
                          && mgmt_access_command == `CMD_IDLE
                          && (wdata_i == `CMD_WRITE
                              || wdata_i == `CMD_READ);
    end

    assign mreq.op = (mgmt_access_command == `CMD_READ)
                     ? phy_mgmt_pkg::MDIO_OP_READ
                     : phy_mgmt_pkg::MDIO_OP_WRITE;
    assign mreq.phy_addr = PHY_ADDR;
    assign mreq.reg_addr = mgmt_reg_address;
    assign mreq.wdata = {mgmt_write_high, mgmt_write_low};
    assign mreq.divider = mgmt_clock_divider;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mgmt_read_low <= 8'h00;
            mgmt_read_high <= 8'h00;
        end
        else if (mreq.done && mgmt_access_command == `CMD_READ)
        begin
            mgmt_read_high <= mreq.rdata[15:8];
            mgmt_read_low <= mreq.rdata[7:0];
        end
    end

    mdio_engine #(
        .PRE_BITS(PRE_BITS)
    ) u_engine (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .req(mreq.eng),
        .mdio_i(mdio_i),
        .mdc_o(mdc_o),
        .mdio_o(mdio_o),
        .mdio_oe_n_o(mdio_oe_n_o)
    );

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (1'b1)
            hit(`OFS_SYSTEM_CONFIG_ONE):
                next_rdata[`BIT_SLOW_CLOCK_SELECT] = slow_clock_select;
            hit(`OFS_PHY_CONTROL_ONE):
            begin
                next_rdata[`BIT_PHY_RUN] = phy_run;
                next_rdata[`BIT_PHY_POWER_DOWN] = phy_power_down;
            end
            hit(`OFS_PHY_MODE_CONTROL):
                next_rdata[2:0] = phy_mode_control;
            hit(`OFS_PHY_LINK_STATUS):
            begin
                // mode is only meaningful once the link is up
                next_rdata[5:3] = link_up_i ? link_mode_i : 3'h0;
                next_rdata[2:0] = link_state_i;
            end
            hit(`OFS_PHY_LOCK_KEY):
                next_rdata[0] = unlocked;
            hit(`OFS_MGMT_REG_ADDRESS):
                next_rdata[4:0] = mgmt_reg_address;
            hit(`OFS_MGMT_WRITE_LOW):
                next_rdata = mgmt_write_low;
            hit(`OFS_MGMT_WRITE_HIGH):
                next_rdata = mgmt_write_high;
            hit(`OFS_MGMT_READ_LOW):
                next_rdata = mgmt_read_low;
            hit(`OFS_MGMT_READ_HIGH):
                next_rdata = mgmt_read_high;
            hit(`OFS_MGMT_ACCESS_COMMAND):
                next_rdata = mgmt_access_command;
            hit(`OFS_MGMT_CLOCK_DIVIDER):
                next_rdata = mgmt_clock_divider;
            hit(`OFS_CLOCK_STATUS):
            begin
                next_rdata[`BIT_CLOCK_FAST] = core_clock_fast_o;
                next_rdata[`BIT_CLOCK_STABLE] = clock_stable_o;
            end
            default:
                next_rdata = 8'h00;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= next_rdata;
        else
            rdata_o <= 8'h00;
    end
endmodule

//--- tb/phy_mgmt_assertions.sv
// checker bound into phy_mgmt below
// sees only the top ports
`include "phy_mgmt_cfg.svh"
module phy_mgmt_chk (
    input mclk_i,
    input nrst_i,
    input [7:0] addr_i,
    input [7:0] wdata_i,
    input wr_i,
    input rd_i,
    input [7:0] rdata_o,
    input link_up_i,
    input [2:0] link_mode_i,
    input [2:0] link_state_i,
    input core_clock_fast_o,
    input clock_stable_o,
    input phy_power_down_o,
    input phy_reset_n_o,
    input [2:0] phy_mode_o,
    input auto_mdix_o,
    input parallel_detect_o,
    input mdc_o,
    input mdio_o,
    input mdio_oe_n_o
);
    logic unlocked;
    logic [2:0] mode_exp;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    // shadow of the lock and of accepted mode writes
    always_ff @(posedge mclk_i or negedge nrst_i)
        if (!nrst_i)
            unlocked <= 1'b0;
        else if (wr_i && addr_i == `OFS_PHY_LOCK_KEY)
            unlocked <= wdata_i == `LOCK_KEY;
    always_ff @(posedge mclk_i or negedge nrst_i)
        if (!nrst_i)
            mode_exp <= 3'h0;
        else if (wr_i && addr_i == `OFS_PHY_MODE_CONTROL && unlocked)
            mode_exp <= wdata_i[2:0];
    AST_SEL_SLOW:
        assert property (wr_i && addr_i == `OFS_SYSTEM_CONFIG_ONE &&
            wdata_i[`BIT_SLOW_CLOCK_SELECT] |-> ##2 !core_clock_fast_o)
        else $error("select not slow");
    AST_PD_SLOW:
        assert property (phy_power_down_o |-> !core_clock_fast_o)
        else $error("fast in power-down");
    AST_SETTLE_LOW:
        assert property ($changed(core_clock_fast_o) |->
            ##1 !clock_stable_o [*5])
        else $error("stable too early");
    AST_SETTLE_END:
        assert property ($fell(clock_stable_o) |-> ##[1:30] clock_stable_o)
        else $error("settle stuck");
    AST_MODE_HOLD:
        assert property ($changed(phy_mode_o) |->
            !phy_reset_n_o || !$past(phy_reset_n_o))
        else $error("mode moved in run");
    AST_MODE_LOCK:
        assert property ($rose(phy_reset_n_o) |-> phy_mode_o == mode_exp)
        else $error("mode wrong");
    AST_STATUS:
        assert property (rd_i && addr_i == `OFS_PHY_LINK_STATUS && link_up_i
            |=> rdata_o == {2'h0, $past(link_mode_i), $past(link_state_i)})
        else $error("status wrong");
    AST_MDIX:
        assert property (auto_mdix_o == !phy_mode_o[`BIT_FORCED_MODE])
        else $error("mdix wrong");
    AST_PDET:
        assert property (parallel_detect_o == !phy_mode_o[`BIT_FORCED_MODE])
        else $error("pdet wrong");
    AST_ACCESS_START:
        assert property (wr_i && addr_i == `OFS_MGMT_ACCESS_COMMAND &&
            (wdata_i == `CMD_WRITE || wdata_i == `CMD_READ) &&
            mdio_oe_n_o && !mdc_o |-> ##[1:4] !mdio_oe_n_o)
        else $error("no start");
    AST_DATA_EDGE:
        assert property (!mdio_oe_n_o && $changed(mdio_o) |-> $fell(mdc_o))
        else $error("data off edge");
endmodule
bind phy_mgmt phy_mgmt_chk phy_mgmt_chk_i (.mclk_i, .nrst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .link_up_i, .link_mode_i,
    .link_state_i, .core_clock_fast_o, .clock_stable_o, .phy_power_down_o,
    .phy_reset_n_o, .phy_mode_o, .auto_mdix_o, .parallel_detect_o, .mdc_o,
    .mdio_o, .mdio_oe_n_o);

//--- tb/mdio_phy_model.sv
// behavioural phy management port: clause 22 frames, 32 registers
// assumes a pull-up on the shared data line outside the model
module mdio_phy_model (
    input mdc_i,
    input mdio_i,
    output logic drive_o,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [32];
    logic [15:0] sh = 16'h0000;
    logic [13:0] hdr = 14'h0000;
    int n = 0;
    int writes = 0;
    initial
    begin
        drive_o = 1'b0;
        data_o = 1'b1;
        for (int i = 0; i < 32; i++)
            mem[i] = {3'h5, 5'(i), 8'h5a};
    end
    // a zero after the idle ones is the first start bit
    always @(posedge mdc_i)
    begin
        sh <= {sh[14:0], mdio_i};
        if (n == 0)
            n <= (mdio_i == 1'b0) ? 1 : 0;
        else
            n <= (n == 31) ? 0 : n + 1;
        if (n == 13)
            hdr <= {sh[12:0], mdio_i};
        if (n == 31 && hdr[11:10] == 2'h1)
        begin
            mem[hdr[4:0]] <= {sh[14:0], mdio_i};
            writes <= writes + 1;
        end
    end
    // turnaround zero, then data msb first, moved on the falling edge
    always @(negedge mdc_i)
    begin
        drive_o <= hdr[11:10] == 2'h2 && n >= 15;
        data_o <= (n > 15) ? mem[hdr[4:0]][31 - n] : 1'b0;
    end
endmodule

//--- tb/phy_mgmt_tb.sv
// bench for phy_mgmt: one task per scenario
// assumes the mdio model and the bound checker
`include "phy_mgmt_cfg.svh"
`define CHK(a, e) \
    begin \
        samples_checked++; \
        if ((a) !== (e)) \
        begin \
            error_cnt++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end
module phy_mgmt_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic link_up_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
    logic [2:0] link_mode_i = 3'h0, link_state_i = 3'h0, phy_mode_o;
    logic core_clock_fast_o, clock_stable_o, phy_power_down_o;
    logic phy_reset_n_o, auto_mdix_o, parallel_detect_o;
    logic mdc_o, mdio_o, mdio_oe_n_o, drv, dbit;
    wire mdio_i = !mdio_oe_n_o ? mdio_o : (drv ? dbit : 1'b1);
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    phy_mgmt #(.PHY_ADDR(5'h00), .PRE_BITS(32)) phy_mgmt_i (.mclk_i,
        .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .link_up_i,
        .link_mode_i, .link_state_i, .core_clock_fast_o, .clock_stable_o,
        .phy_power_down_o, .phy_reset_n_o, .phy_mode_o, .auto_mdix_o,
        .parallel_detect_o, .mdc_o, .mdio_o, .mdio_oe_n_o, .mdio_i);
    mdio_phy_model mdio_phy_model_i (.mdc_i(mdc_o), .mdio_i,
        .drive_o(drv), .data_o(dbit));
    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ceiling well above what the scenarios need
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic ctl(input logic [7:0] d);
        wr(`OFS_PHY_LOCK_KEY, `LOCK_KEY);
        wr(`OFS_PHY_CONTROL_ONE, d);
        wr(`OFS_PHY_LOCK_KEY, 8'h00);
    endtask
    task automatic poll();
        for (int k = 0; k < 1000; k++)
        begin
            rd(`OFS_MGMT_ACCESS_COMMAND, v);
            if (v === `CMD_IDLE)
                break;
        end
        `CHK(v, `CMD_IDLE)
    endtask
    task automatic t_reset();
        step(1);
        `CHK(core_clock_fast_o, 1'b1)
        rd(`OFS_PHY_CONTROL_ONE, v);
        `CHK(v, `RST_PHY_CONTROL_ONE)
        rd(`OFS_PHY_LOCK_KEY, v);
        `CHK(v[0], 1'b0)
        rd(`OFS_MGMT_CLOCK_DIVIDER, v);
        `CHK(v, `RST_MGMT_CLOCK_DIVIDER)
        rd(8'h0d, v);
        `CHK(v, 8'h00)
        $display("test reset done");
    endtask
    task automatic t_lock();
        logic [2:0] codes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
        logic [2:0] prev = 3'h0;
        wr(`OFS_PHY_MODE_CONTROL, 8'h04);
        rd(`OFS_PHY_MODE_CONTROL, v);
        `CHK(v, 8'h00)
        wr(`OFS_PHY_LOCK_KEY, `LOCK_KEY);
        rd(`OFS_PHY_LOCK_KEY, v);
        `CHK(v[0], 1'b1)
        foreach (codes[i])
        begin
            wr(`OFS_PHY_MODE_CONTROL, {5'h00, codes[i]});
            step(1);
            `CHK(phy_mode_o, prev)
            wr(`OFS_PHY_CONTROL_ONE, 8'h80);
            step(1);
            `CHK(phy_reset_n_o, 1'b0)
            step(11);
            `CHK(phy_reset_n_o, 1'b1)
            `CHK(phy_mode_o, codes[i])
            `CHK(auto_mdix_o, !codes[i][2])
            `CHK(parallel_detect_o, !codes[i][2])
            prev = codes[i];
        end
        wr(`OFS_PHY_LOCK_KEY, 8'h00);
        rd(`OFS_PHY_LOCK_KEY, v);
        `CHK(v[0], 1'b0)
        wr(`OFS_PHY_MODE_CONTROL, 8'h04);
        rd(`OFS_PHY_MODE_CONTROL, v);
        `CHK(v[2:0], 3'h0)
        $display("test lock done");
    endtask
    task automatic t_clock();
        wr(`OFS_SYSTEM_CONFIG_ONE, 8'h01);
        step(1);
        `CHK(core_clock_fast_o, 1'b0)
        `CHK(clock_stable_o, 1'b0)
        step(12);
        `CHK(clock_stable_o, 1'b1)
        wr(`OFS_SYSTEM_CONFIG_ONE, 8'h00);
        step(13);
        `CHK(core_clock_fast_o, 1'b1)
        ctl(8'ha0);
        step(13);
        `CHK(phy_power_down_o, 1'b1)
        `CHK(core_clock_fast_o, 1'b0)
        ctl(8'h80);
        step(30);
        `CHK(phy_power_down_o, 1'b0)
        `CHK(core_clock_fast_o, 1'b1)
        rd(`OFS_CLOCK_STATUS, v);
        `CHK(v, 8'h03)
        ctl(8'h00);
        step(13);
        `CHK(core_clock_fast_o, 1'b0)
        ctl(8'h80);
        step(30);
        `CHK(core_clock_fast_o, 1'b1)
        $display("test clock done");
    endtask
    task automatic t_status();
        @(posedge mclk_i);
        link_up_i <= 1'b1;
        link_mode_i <= 3'h5;
        link_state_i <= 3'h3;
        rd(`OFS_PHY_LINK_STATUS, v);
        `CHK(v, 8'h2b)
        @(posedge mclk_i);
        link_up_i <= 1'b0;
        rd(`OFS_PHY_LINK_STATUS, v);
        `CHK(v, 8'h03)
        $display("test status done");
    endtask
    task automatic t_mdio();
        time t0;
        wr(`OFS_MGMT_REG_ADDRESS, 8'h09);
        wr(`OFS_MGMT_WRITE_HIGH, 8'ha5);
        wr(`OFS_MGMT_WRITE_LOW, 8'h3c);
        wr(`OFS_MGMT_ACCESS_COMMAND, `CMD_WRITE);
        poll();
        `CHK(mdio_phy_model_i.mem[9], 16'ha53c)
        `CHK(mdio_phy_model_i.hdr[9:5], 5'h00)
        wr(`OFS_MGMT_CLOCK_DIVIDER, 8'h03);
        wr(`OFS_MGMT_REG_ADDRESS, 8'h02);
        wr(`OFS_MGMT_ACCESS_COMMAND, `CMD_READ);
        @(posedge mdc_o);
        t0 = $time;
        @(posedge mdc_o);
        `CHK(int'(($time - t0) / 40), 2 * (3 + 1))
        // dropped while busy
        wr(`OFS_MGMT_ACCESS_COMMAND, `CMD_WRITE);
        poll();
        `CHK(mdio_phy_model_i.writes, 1)
        rd(`OFS_MGMT_READ_HIGH, v);
        `CHK(v, 8'ha2)
        rd(`OFS_MGMT_READ_LOW, v);
        `CHK(v, 8'h5a)
        $display("test mdio done");
    endtask
    initial
    begin
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_lock();
        t_clock();
        t_status();
        t_mdio();
        finish_test();
    end
endmodule
